// [hdl/sami_map.vh]
// timing counts and field positions of the serial converter interface
`ifndef SAMI_MAP_VH
`define SAMI_MAP_VH
`define SAMI_RESULT_BITS 8
`define SAMI_SGL_POS 3
`define SAMI_ODD_POS 2
`define SAMI_SEL_HI_POS 1
`define SAMI_SEL_LO_POS 0
`define SAMI_DESELECT_MIN_NS 250
`define SAMI_CLK_PERIOD_NS 8
`define SAMI_DESELECT_CYCLES ((`SAMI_DESELECT_MIN_NS + `SAMI_CLK_PERIOD_NS - 1) / `SAMI_CLK_PERIOD_NS)
`endif

// [hdl/sami_serial_adc.v]
// serial control and data interface of an 8-bit multiplexed converter
`timescale 1ns/1ns
`default_nettype none
// Contract
// - serial input sampled on each rising serial clock during addressing
// - leading zeros ignored; first one is the start bit
// - zero, three or four mux bits follow the start bit, per variant
// - eight-channel differential: select picks pair, odd bit picks polarity
// - four-channel: single-ended channel 2*sel+odd, or differential pair
// - new mux configuration accepted with every conversion
// - half clock for sampling, then active flag high, input ignored
// - serial output leaves high impedance with one leading zero
// - comparator decisions driven on falling edge, msb first
// - conversion ends after eight periods; flag drops half clock later
// - result copied to shift register; shift enable low shifts lsb first
// - without shift enable pin, lsb first follows automatically
// - after lsb first data, output low until chip select high
// - sequencer state cleared after chip select high for deselect time; mux word and result buffer kept
// - serial input looked at only while output is high impedance
// - eight-channel single-ended: channel 2*sel+odd against common
// - single-channel variant needs no mux bits
// - positive input below negative gives all-zeros code
`include "sami_map.vh"

module sami_serial_adc #(
	parameter CHANNELS = 8,
	parameter HAS_SHIFT_ENABLE = 1,
	parameter DESELECT_CYCLES = `SAMI_DESELECT_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire rst_b,
	// serial pins
	input wire chip_select_n,
	input wire serial_clk,
	input wire serial_in_line,
	input wire lsb_shift_enable_n,
	output reg serial_out,
	output reg serial_out_oe,
	output reg conversion_active_flag,
	// analog front end
	output reg [3:0] mux_word,
	output reg mux_valid,
	output reg sample_strobe,
	input wire comp_greater,
	output reg [7:0] trial_code,
	// result stream to user, two-entry buffer
	output reg [7:0] result_data,
	output reg result_valid,
	input wire result_ready
);

localparam ST_IDLE = 7'h01;
localparam ST_ADDR = 7'h02;
localparam ST_SAMP = 7'h04;
localparam ST_CONV = 7'h08;
localparam ST_LSB = 7'h10;
localparam ST_LOW = 7'h20;
localparam ST_DONE = 7'h40;

localparam [2:0] MUX_BITS = (CHANNELS >= 8) ? 3'h4 : (CHANNELS >= 4) ? 3'h3 : 3'h0;

// =====================================================
// pin synchronisers
reg [1:0] cs_sync;
reg [1:0] clk_sync;
reg [1:0] din_sync;
reg [1:0] se_sync;
reg clk_prev;
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		cs_sync <= 2'h3;
		clk_sync <= 2'h0;
		din_sync <= 2'h0;
		se_sync <= 2'h3;
		clk_prev <= 1'b0;
	end else begin
		cs_sync <= {cs_sync[0], chip_select_n};
		clk_sync <= {clk_sync[0], serial_clk};
		din_sync <= {din_sync[0], serial_in_line};
		se_sync <= {se_sync[0], lsb_shift_enable_n};
		clk_prev <= clk_sync[1];
	end
end
wire cs_n = cs_sync[1];
wire sclk_rise = clk_sync[1] & ~clk_prev;
wire sclk_fall = ~clk_sync[1] & clk_prev;
wire se_low = (HAS_SHIFT_ENABLE != 0) ? ~se_sync[1] : 1'b1;

// =====================================================
// deselect timer
reg [15:0] desel_cnt;
wire desel_met = (desel_cnt >= DESELECT_CYCLES[15:0]);
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		desel_cnt <= 16'h0000;
	end else if (!cs_n) begin
		desel_cnt <= 16'h0000;
	end else if (!desel_met) begin
		desel_cnt <= desel_cnt + 16'h0001;
	end
end

// =====================================================
// two-entry result buffer
reg [7:0] buf_data [0:1];
reg [1:0] buf_cnt;
reg buf_wr_ptr;
reg buf_rd_ptr;
reg push;
reg [7:0] push_data;
wire buf_full = (buf_cnt == 2'h2);
wire pop = result_valid & result_ready;
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		buf_cnt <= 2'h0;
		buf_wr_ptr <= 1'b0;
		buf_rd_ptr <= 1'b0;
		result_valid <= 1'b0;
		result_data <= 8'h00;
		buf_data[0] <= 8'h00;
		buf_data[1] <= 8'h00;
	end else begin
		if (push && !buf_full) begin
			buf_data[buf_wr_ptr] <= push_data;
			buf_wr_ptr <= ~buf_wr_ptr;
		end
		if (pop) begin
			buf_rd_ptr <= ~buf_rd_ptr;
		end
		buf_cnt <= buf_cnt + {1'b0, push & ~buf_full} - {1'b0, pop};
		if (pop || !result_valid) begin
			if (buf_cnt - {1'b0, pop} != 2'h0) begin
				result_valid <= 1'b1;
				result_data <= buf_data[pop ? ~buf_rd_ptr : buf_rd_ptr];
			end else if (push && !buf_full) begin
				result_valid <= 1'b1;
				result_data <= push_data;
			end else begin
				result_valid <= 1'b0;
			end
		end
	end
end

// =====================================================
// conversion sequencer
reg [6:0] state;
reg [3:0] addr_sr;
reg [2:0] addr_cnt;
reg [3:0] bit_cnt;
reg [7:0] sar;
reg [7:0] out_sr;
reg [7:0] test_bit;
reg pend_push;

// =====================================================
// successive approximation step
reg [7:0] next_sar;
reg [7:0] next_test_bit;
reg [7:0] next_trial;
always @* begin
	next_sar = sar;
	next_test_bit = {1'b0, test_bit[7:1]};
	next_trial = trial_code;
	if (comp_greater) begin
		// comparator low also covers reversed inputs
		next_sar = sar | test_bit;
	end
	// decided bits kept, next trial bit added
	next_trial = next_sar | next_test_bit;
end

// =====================================================
// mux word decode per variant
reg [3:0] next_mux_word;
always @* begin
	next_mux_word = 4'h0;
	if (MUX_BITS == 3'h4) begin
		// single_or_diff_bit, odd, sel1, sel0
		next_mux_word = addr_sr;
	end else if (MUX_BITS == 3'h3) begin
		// single_or_diff_bit, odd, unused zero, sel
		next_mux_word = {addr_sr[2:1], 1'b0, addr_sr[0]};
	end else begin
		// one fixed pair, no address bits
		next_mux_word = 4'h0;
	end
end

// =====================================================
// lsb first output shift step
reg [7:0] next_out_sr;
reg next_serial_bit;
reg lsb_step;
always @* begin
	lsb_step = sclk_fall & se_low;
	next_out_sr = out_sr;
	next_serial_bit = serial_out;
	if (lsb_step) begin
		// lsb already shown as last msb first bit
		next_out_sr = {1'b0, out_sr[7:1]};
		next_serial_bit = out_sr[1];
	end
end

// =====================================================
// end of conversion and flag release
wire conv_last = (bit_cnt == 4'h7);
wire lsb_last = (bit_cnt == 4'h7);
wire flag_release = sclk_rise & conversion_active_flag;

// =====================================================
// sequencer state
always @(posedge mclk or negedge rst_b) begin
	if (!rst_b) begin
		state <= ST_IDLE;
		addr_sr <= 4'h0;
		addr_cnt <= 3'h0;
		bit_cnt <= 4'h0;
		sar <= 8'h00;
		out_sr <= 8'h00;
		test_bit <= 8'h00;
		pend_push <= 1'b0;
		push <= 1'b0;
		push_data <= 8'h00;
		serial_out <= 1'b0;
		serial_out_oe <= 1'b0;
		conversion_active_flag <= 1'b0;
		mux_word <= 4'h0;
		mux_valid <= 1'b0;
		sample_strobe <= 1'b0;
		trial_code <= 8'h00;
	end else begin
		push <= 1'b0;
		sample_strobe <= 1'b0;
		if (pend_push && !buf_full) begin
			push <= 1'b1;
			pend_push <= 1'b0;
		end
		if (cs_n) begin
			serial_out_oe <= 1'b0;
			conversion_active_flag <= 1'b0;
			if (desel_met) begin
				state <= ST_IDLE;
				addr_sr <= 4'h0;
				addr_cnt <= 3'h0;
				bit_cnt <= 4'h0;
				sar <= 8'h00;
				out_sr <= 8'h00;
				test_bit <= 8'h00;
				serial_out <= 1'b0;
				mux_valid <= 1'b0;
				trial_code <= 8'h00;
			end
		end else begin
			case (state)
				ST_IDLE: begin
					if (sclk_rise && din_sync[1]) begin
						addr_cnt <= 3'h0;
						addr_sr <= 4'h0;
						state <= (MUX_BITS == 3'h0) ? ST_SAMP : ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						addr_sr <= {addr_sr[2:0], din_sync[1]};
						addr_cnt <= addr_cnt + 3'h1;
						if (addr_cnt + 3'h1 == MUX_BITS) begin
							state <= ST_SAMP;
						end
					end
				end
				ST_SAMP: begin
					// new configuration every conversion
					mux_word <= next_mux_word;
					mux_valid <= 1'b1;
					if (sclk_fall) begin
						sample_strobe <= 1'b1;
						conversion_active_flag <= 1'b1;
						serial_out_oe <= 1'b1;
						serial_out <= 1'b0;
						sar <= 8'h00;
						trial_code <= 8'h80;
						test_bit <= 8'h80;
						bit_cnt <= 4'h0;
						state <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (sclk_fall) begin
						sar <= next_sar;
						serial_out <= comp_greater;
						trial_code <= next_trial;
						test_bit <= next_test_bit;
						bit_cnt <= bit_cnt + 4'h1;
						if (conv_last) begin
							out_sr <= next_sar;
							push_data <= next_sar;
							pend_push <= 1'b1;
							bit_cnt <= 4'h1;
							state <= ST_LSB;
						end
					end
				end
				ST_LSB: begin
					if (flag_release) begin
						conversion_active_flag <= 1'b0;
					end
					if (lsb_step) begin
						out_sr <= next_out_sr;
						serial_out <= next_serial_bit;
						bit_cnt <= bit_cnt + 4'h1;
						if (lsb_last) begin
							state <= ST_LOW;
						end
					end
				end
				ST_LOW: begin
					if (sclk_fall) begin
						serial_out <= 1'b0;
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					serial_out <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
end

endmodule // sami_serial_adc
`default_nettype wire

// [bench/sami_host_model.sv]
// host serial port model for the converter pins
`timescale 1ns/1ns
`default_nettype none
module sami_host_model (
	// clock
	input wire logic mclk,
	// serial pins
	output logic chip_select_n = 1'b1,
	output logic serial_clk = 1'b0,
	output logic serial_in_line = 1'b0,
	output logic lsb_shift_enable_n = 1'b0,
	input wire logic serial_out
);
	logic got [0:17];
	task automatic half;
		repeat (8) @(negedge mclk);
	endtask
	// two zeros, start bit, mux msb first, n more periods
	task automatic convert(input logic [3:0] mux, input logic se_n, input int n);
		lsb_shift_enable_n = se_n;
		chip_select_n = 1'b0;
		half;
		for (int i = -2; i < 5 + n; i++) begin
			serial_in_line = i < 5 ? (i == 0 || (i > 0 && mux[4 - i])) : !serial_in_line;
			half;
			if (i >= 5)
				got[i - 5] = serial_out;
			serial_clk = 1'b1;
			half;
			serial_clk = 1'b0;
		end
		half;
		chip_select_n = 1'b1;
		repeat (12) @(negedge mclk);
	endtask
endmodule // sami_host_model
`default_nettype wire

// [bench/sami_serial_adc_checker.sv]
// assertions on the ports of the serial converter interface
`timescale 1ns/1ns
`default_nettype none
module sami_serial_adc_checker (
	// clock, reset, pins
	input wire mclk,
	input wire rst_b,
	input wire chip_select_n,
	input wire serial_clk,
	input wire serial_out,
	input wire serial_out_oe,
	input wire conversion_active_flag,
	// front end and stream
	input wire [3:0] mux_word,
	input wire sample_strobe,
	input wire [7:0] result_data,
	input wire result_valid,
	input wire result_ready
);
	logic sclk_d;
	logic [3:0] rises;
	// serial clock rises while converting
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_d <= 1'b0;
			rises <= 4'h0;
		end else begin
			sclk_d <= serial_clk;
			rises <= !conversion_active_flag ? 4'h0 : rises + {3'h0, serial_clk & !sclk_d};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	cs_idle_a:
	assert property (chip_select_n [*5] |-> !serial_out_oe && !conversion_active_flag)
		else $error("driven while idle");
	flag_oe_a:
	assert property (conversion_active_flag |-> serial_out_oe) else $error("flag without oe");
	lead_zero_a:
	assert property ($rose(serial_out_oe) |-> !serial_out) else $error("no leading zero");
	strobe_flag_a:
	assert property (sample_strobe |-> ##[0:2] conversion_active_flag) else $error("no flag");
	strobe_pulse_a:
	assert property (sample_strobe |=> !sample_strobe) else $error("long strobe");
	mux_hold_a:
	assert property (conversion_active_flag [*2] |-> $stable(mux_word)) else $error("mux moved");
	flag_len_a:
	assert property ($fell(conversion_active_flag) && !chip_select_n |-> rises >= 4'h8
		&& rises <= 4'h9) else $error("bad length");
	buf_hold_a:
	assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
		else $error("result lost");
endmodule // sami_serial_adc_checker
bind sami_serial_adc sami_serial_adc_checker sami_serial_adc_checker_inst (.mclk, .rst_b,
	.chip_select_n, .serial_clk, .serial_out, .serial_out_oe, .conversion_active_flag,
	.mux_word, .sample_strobe, .result_data, .result_valid, .result_ready);
`default_nettype wire

// [bench/sami_serial_adc_tb_top.sv]
// self-checking bench of the serial converter interface
`timescale 1ns/1ns
`default_nettype none
module sami_serial_adc_tb_top;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic result_ready = 1'b0;
	logic [7:0] vin = 8'h00;
	wire chip_select_n, serial_clk, serial_in_line, lsb_shift_enable_n, serial_out;
	wire serial_out_oe, conversion_active_flag, mux_valid, sample_strobe, result_valid;
	wire [3:0] mux_word;
	wire [7:0] trial_code, result_data;
	wire comp_greater = trial_code <= vin;
	int errors = 0;
	int total_checks = 0;
	// rows: analog level, expected code
	logic [15:0] rows [0:3] = '{16'hFFFF, 16'h0000, 16'h8080, 16'h0101};
	always #4 mclk = ~mclk;
	sami_serial_adc #(.DESELECT_CYCLES(4)) sami_serial_adc_inst (.mclk, .rst_b,
		.chip_select_n, .serial_clk, .serial_in_line, .lsb_shift_enable_n, .serial_out,
		.serial_out_oe, .conversion_active_flag, .mux_word, .mux_valid, .sample_strobe,
		.comp_greater, .trial_code, .result_data, .result_valid, .result_ready);
	sami_host_model sami_host_model_inst (.mclk, .chip_select_n, .serial_clk,
		.serial_in_line, .lsb_shift_enable_n, .serial_out);
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic exp_bit(input int j, input logic se_n);
		if (j == 0)
			return 1'b0;
		if (j <= 8)
			return vin[8 - j];
		if (j <= 15)
			return se_n ? vin[0] : vin[j - 8];
		return se_n ? vin[0] : 1'b0;
	endfunction
	task automatic convert_check(input logic [3:0] mux, input logic se_n);
		fork
			sami_host_model_inst.convert(mux, se_n, 18);
			begin
				@(posedge sample_strobe);
				@(negedge mclk);
				check("mux_word", {4'h0, mux}, {4'h0, mux_word});
			end
		join
		for (int j = 0; j < 18; j++)
			check("serial_out", {7'h0, exp_bit(j, se_n)}, {7'h0, sami_host_model_inst.got[j]});
	endtask
	task automatic pop(input logic [7:0] exp);
		for (int k = 0; k < 40 && result_valid !== 1'b1; k++)
			@(negedge mclk);
		check("result_valid", 8'h01, {7'h0, result_valid});
		check("result_data", exp, result_data);
		result_ready = 1'b1;
		@(negedge mclk);
		result_ready = 1'b0;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		repeat (4) @(negedge mclk);
		check("oe", 8'h00, {7'h0, serial_out_oe});
		for (int i = 0; i < 16; i++) begin
			vin = rows[i % 4][15:8];
			convert_check(i[3:0], 1'b0);
			pop(rows[i % 4][7:0]);
		end
		vin = 8'h96;
		convert_check(4'hB, 1'b1);
		pop(8'h96);
		// abort mid conversion, then a clean one
		sami_host_model_inst.convert(4'h0, 1'b0, 4);
		vin = 8'h3C;
		convert_check(4'h2, 1'b0);
		pop(8'h3C);
		// third result held until the buffer has room
		for (int i = 1; i < 4; i++) begin
			vin = 8'(i * 17);
			convert_check(4'h9, 1'b0);
		end
		pop(8'h11);
		pop(8'h22);
		pop(8'h33);
		repeat (8) @(negedge mclk);
		check("empty", 8'h00, {7'h0, result_valid});
		final_report;
	end
	initial begin
		#300000;
		errors++;
		final_report;
	end
endmodule // sami_serial_adc_tb_top
`default_nettype wire
